// ===== srcp_pkg.sv
/*
  package for the sleep and reset control block: register map, field
  positions, reset values, mode codes and timing counts.
  assumes a 100 MHz pclk and an APB master with 32-bit data.
*/
package srcp_pkg;
  // byte addresses on APB
  localparam logic [7:0] SLEEP_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] RESET_CAUSE_FLAGS_ADDR = 8'h04;
  localparam logic [7:0] SOFT_RESET_REGISTER_ADDR = 8'h08;
  localparam logic [7:0] SLEEP_STATUS_ADDR = 8'h0C;
  // sleep_control fields
  localparam int SLEEP_ENABLE_BIT_POS = 0;
  localparam int SLEEP_DEPTH_LSB = 1;
  localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SLEEP_CONTROL_MASK = 8'h07;
  // sleep depth codes
  localparam logic [1:0] DEPTH_IDLE = 2'h0;
  localparam logic [1:0] DEPTH_STANDBY = 2'h1;
  localparam logic [1:0] POWER_DOWN_CODE = 2'h2;
  // reset cause flag positions
  localparam int FLAG_POWER_ON = 0;
  localparam int FLAG_BROWNOUT = 1;
  localparam int FLAG_PIN = 2;
  localparam int FLAG_WATCHDOG = 3;
  localparam int FLAG_SOFTWARE = 4;
  localparam int FLAG_DEBUG = 5;
  localparam int NUM_FLAGS = 6;
  localparam int SOFT_RESET_TRIGGER_POS = 0;
  // brown-out fuse mode that waits for detector ready
  localparam logic [1:0] BOD_WAIT_MODE = 2'h3;
  // timing
  localparam int WAKE_CYCLES = 6;
  localparam int INIT_CYCLES = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_STARTUP_NS = 200;
  localparam int OSC_STARTUP_CYCLES =
    (OSC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUT_STEP_NS = 1000;
  localparam int SUT_STEP_CYCLES =
    (SUT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // reset sequencer states
  typedef enum logic [2:0] {
    RST_HOLD = 3'b001,
    RST_INIT = 3'b010,
    RST_RUN = 3'b100
  } srcp_rst_state_t;
  // sleep controller states
  typedef enum logic [2:0] {
    SLP_ACTIVE = 3'b001,
    SLP_ASLEEP = 3'b010,
    SLP_WAKING = 3'b100
  } srcp_slp_state_t;
endpackage

// ===== srcp_sync_if.sv
/*
  interface carrying the raw asynchronous reset-source levels to the
  synchroniser and the filtered levels back.
  assumes all raw inputs are levels, not pulses.
*/
interface srcp_sync_if;
  logic [4:0] raw;
  logic [4:0] clean;
  modport src (output raw, input clean);
  modport snk (input raw, output clean);
endinterface

// ===== srcp_sync.sv
/*
  three flop synchronisers for asynchronous pin and detector levels;
  a change counts once the second and third stage agree.
  assumes pclk free running.
*/
module srcp_sync #(
  parameter int WIDTH = 5,
  parameter logic [4:0] RESET_VAL = 5'h00
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  srcp_sync_if.snk sif
);
  initial begin
    if (WIDTH != 5) begin
      $error("srcp_sync width must be 5");
    end
  end
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  logic [4:0] out_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end else begin
      s1_r <= sif.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // per bit: accept a new level only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= RESET_VAL;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          out_r[i] <= s3_r[i];
        end
      end
    end
  end
  assign sif.clean = out_r;
endmodule

// ===== srcp_top.sv
/*
  sleep and reset control: sleep mode register and wake sequencing,
  reset source collection, reset sequencing, fuse reload request and
  reset cause flags, all on APB.
  assumes presetn is the power-on reset from the supply detector, and
  the core, watchdog and debug port drive their request levels here.
*/
// Summary of operation
// - wake takes 6 clocks from idle, plus oscillator start from deeper modes.
// - brown-out fuse mode 3 holds code after wake until detector ready.
// - with that wait, latency is the longer of normal wake and ready.
// - a debug break wakes the device even without pending interrupt.
// - sleep depth field bits 2:1: 0 idle, 1 standby, 2 power-down.
// - controller always runs; sources reset only when enabled.
// - every reset requests a reload of fuse and signature registers.
// - each reset records its cause in the reset cause flags.
// - power-on holds reset until start-up delay and init complete.
// - supply falling below detection level re-enters reset at once.
// - brown-out level from fuse, forced minimum in reset when unused.
// - reset pin is a source only when its fuse enables it.
// - enabled pin holds reset while low, releases after it goes high.
// - watchdog time-out issues a watchdog reset.
// - writing one to soft reset trigger generates full system reset.
// - soft reset acts at once and holds until sequence completes.
// - debug-port reset is driven only from the debug interface.
// - cause flags clear on write one; power-on clears all but its own.
// - soft reset trigger always reads back zero.
module srcp_top #(
  parameter int WAKE_CNT = srcp_pkg::WAKE_CYCLES,
  parameter int OSC_CNT = srcp_pkg::OSC_STARTUP_CYCLES,
  parameter int INIT_CNT = srcp_pkg::INIT_CYCLES,
  parameter int SUT_STEP = srcp_pkg::SUT_STEP_CYCLES
) (
  // clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fuses
  input wire logic [1:0] bod_active_fuse,
  input wire logic [2:0] bod_level_fuse,
  input wire logic bod_used_fuse,
  input wire logic reset_pin_config,
  input wire logic [2:0] startup_delay_setting,
  // asynchronous reset sources and detector
  input wire logic supply_low,
  input wire logic brownout_trip,
  input wire logic brownout_ready,
  input wire logic reset_pin_n,
  // same-clock requests
  input wire logic watchdog_timeout,
  input wire logic debug_port_reset,
  input wire logic debug_break,
  input wire logic sleep_instr,
  input wire logic wake_irq,
  // outputs
  output logic sys_reset_n,
  output logic fuse_reload,
  output logic cpu_run,
  output logic [1:0] sleep_mode_out,
  output logic asleep,
  output logic [2:0] bod_level_out
);
  initial begin
    if (WAKE_CNT < 1 || OSC_CNT < 0 || INIT_CNT < 1 || SUT_STEP < 1 ||
        WAKE_CNT + OSC_CNT >= 2 ** srcp_pkg::CNT_W ||
        INIT_CNT + 7 * SUT_STEP >= 2 ** srcp_pkg::CNT_W) begin
      $error("srcp_top counts out of range");
    end
  end

  function automatic logic [15:0] cnt16(input int v);
    cnt16 = v[15:0];
  endfunction

  // synchronised asynchronous levels: supply_low, trip, ready, pin_n
  srcp_sync_if sif();
  assign sif.raw = {1'b0, reset_pin_n, brownout_ready, brownout_trip,
                    supply_low};
  srcp_sync #(.WIDTH(5), .RESET_VAL(5'h08)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sif(sif)
  );
  logic supply_low_s;
  logic bod_trip_s;
  logic bod_ready_s;
  logic pin_n_s;
  assign supply_low_s = sif.clean[0];
  assign bod_trip_s = sif.clean[1];
  assign bod_ready_s = sif.clean[2];
  assign pin_n_s = sif.clean[3];

  // apb decode
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign mapped = paddr == srcp_pkg::SLEEP_CONTROL_ADDR ||
                  paddr == srcp_pkg::RESET_CAUSE_FLAGS_ADDR ||
                  paddr == srcp_pkg::SOFT_RESET_REGISTER_ADDR ||
                  paddr == srcp_pkg::SLEEP_STATUS_ADDR;

  // reset source requests; pin and brown-out each gated by its fuse enable
  logic soft_req;
  logic pin_req;
  logic bod_req;
  logic [srcp_pkg::NUM_FLAGS-1:0] src_vec;
  assign soft_req = wr && pready == 1'b0 &&
                    paddr == srcp_pkg::SOFT_RESET_REGISTER_ADDR &&
                    pwdata[srcp_pkg::SOFT_RESET_TRIGGER_POS];
  assign pin_req = reset_pin_config && !pin_n_s;
  assign bod_req = bod_used_fuse && bod_trip_s;
  always_comb begin
    src_vec = '0;
    src_vec[srcp_pkg::FLAG_BROWNOUT] = bod_req;
    src_vec[srcp_pkg::FLAG_PIN] = pin_req;
    src_vec[srcp_pkg::FLAG_WATCHDOG] = watchdog_timeout;
    src_vec[srcp_pkg::FLAG_SOFTWARE] = soft_req;
    src_vec[srcp_pkg::FLAG_DEBUG] = debug_port_reset;
  end

  // reset sequencer
  srcp_pkg::srcp_rst_state_t rst_st_r;
  logic [15:0] rst_cnt_r;
  logic por_seq_r;
  logic [15:0] init_len;
  assign init_len = por_seq_r ?
    cnt16(INIT_CNT) + 16'(startup_delay_setting) * cnt16(SUT_STEP) :
    cnt16(INIT_CNT);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_st_r <= srcp_pkg::RST_HOLD;
      rst_cnt_r <= 16'h0000;
      por_seq_r <= 1'b1;
    end else if (supply_low_s) begin
      rst_st_r <= srcp_pkg::RST_HOLD;
      rst_cnt_r <= 16'h0000;
      por_seq_r <= 1'b1;
    end else if (|src_vec) begin
      rst_st_r <= srcp_pkg::RST_HOLD;
      rst_cnt_r <= 16'h0000;
      if (src_vec[srcp_pkg::FLAG_BROWNOUT]) begin
        por_seq_r <= 1'b1;
      end
    end else begin
      case (rst_st_r)
        srcp_pkg::RST_HOLD: begin
          rst_st_r <= srcp_pkg::RST_INIT;
          rst_cnt_r <= 16'h0000;
        end
        srcp_pkg::RST_INIT: begin
          if (rst_cnt_r + 16'h0001 >= init_len) begin
            rst_st_r <= srcp_pkg::RST_RUN;
            por_seq_r <= 1'b0;
          end
          rst_cnt_r <= rst_cnt_r + 16'h0001;
        end
        srcp_pkg::RST_RUN: rst_st_r <= srcp_pkg::RST_RUN;
        default: rst_st_r <= srcp_pkg::RST_HOLD;
      endcase
    end
  end
  logic in_reset;
  assign in_reset = rst_st_r != srcp_pkg::RST_RUN;

  // system reset, fuse reload and brown-out level outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_n <= 1'b0;
      fuse_reload <= 1'b0;
      bod_level_out <= 3'h0;
    end else begin
      sys_reset_n <= !in_reset && !(|src_vec) && !supply_low_s;
      fuse_reload <= rst_st_r == srcp_pkg::RST_HOLD;
      bod_level_out <= (!bod_used_fuse && in_reset) ? 3'h0 :
                       bod_level_fuse;
    end
  end

  // reset cause flags: set wins over write-one clear
  logic [srcp_pkg::NUM_FLAGS-1:0] flags_r;
  logic flag_wr;
  assign flag_wr = wr && !pready &&
                   paddr == srcp_pkg::RESET_CAUSE_FLAGS_ADDR;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= 6'h01;
    end else if (supply_low_s) begin
      flags_r <= 6'h01;
    end else begin
      flags_r <= (flags_r & ~(flag_wr ? pwdata[5:0] : 6'h00)) |
                 src_vec;
    end
  end

  // sleep control register
  logic [7:0] sleep_control_r;
  logic sleep_enable_bit;
  logic [1:0] sleep_depth_select;
  assign sleep_enable_bit =
    sleep_control_r[srcp_pkg::SLEEP_ENABLE_BIT_POS];
  assign sleep_depth_select =
    sleep_control_r[srcp_pkg::SLEEP_DEPTH_LSB +: 2];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_control_r <= srcp_pkg::SLEEP_CONTROL_RESET;
    end else if (in_reset) begin
      sleep_control_r <= srcp_pkg::SLEEP_CONTROL_RESET;
    end else if (wr && !pready &&
                 paddr == srcp_pkg::SLEEP_CONTROL_ADDR) begin
      sleep_control_r <= pwdata[7:0] & srcp_pkg::SLEEP_CONTROL_MASK;
    end
  end

  // sleep sequencer
  srcp_pkg::srcp_slp_state_t slp_st_r;
  logic [15:0] wake_cnt_r;
  logic [15:0] wake_len_r;
  logic bod_wait;
  logic wake_done;
  assign bod_wait = bod_active_fuse == srcp_pkg::BOD_WAIT_MODE;
  assign wake_done = wake_cnt_r + 16'h0001 >= wake_len_r &&
                     (!bod_wait || bod_ready_s);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp_st_r <= srcp_pkg::SLP_ACTIVE;
      wake_cnt_r <= 16'h0000;
      wake_len_r <= 16'h0000;
    end else if (in_reset) begin
      slp_st_r <= srcp_pkg::SLP_ACTIVE;
      wake_cnt_r <= 16'h0000;
    end else begin
      case (slp_st_r)
        srcp_pkg::SLP_ACTIVE: begin
          if (sleep_instr && sleep_enable_bit &&
              sleep_depth_select != 2'h3) begin
            slp_st_r <= srcp_pkg::SLP_ASLEEP;
            wake_len_r <= sleep_depth_select == srcp_pkg::DEPTH_IDLE ?
              cnt16(WAKE_CNT) : cnt16(WAKE_CNT + OSC_CNT);
          end
        end
        srcp_pkg::SLP_ASLEEP: begin
          if (wake_irq || debug_break) begin
            slp_st_r <= srcp_pkg::SLP_WAKING;
            wake_cnt_r <= 16'h0000;
          end
        end
        srcp_pkg::SLP_WAKING: begin
          if (wake_done) begin
            slp_st_r <= srcp_pkg::SLP_ACTIVE;
          end
          if (wake_cnt_r != 16'hFFFF) begin
            wake_cnt_r <= wake_cnt_r + 16'h0001;
          end
        end
        default: slp_st_r <= srcp_pkg::SLP_ACTIVE;
      endcase
    end
  end

  // core run and sleep status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_run <= 1'b0;
      asleep <= 1'b0;
      sleep_mode_out <= srcp_pkg::DEPTH_IDLE;
    end else begin
      cpu_run <= !in_reset && slp_st_r == srcp_pkg::SLP_ACTIVE;
      asleep <= slp_st_r == srcp_pkg::SLP_ASLEEP;
      sleep_mode_out <= sleep_depth_select;
    end
  end

  // apb: one wait state, answer in the access cycle's second edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (acc && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      case (paddr)
        srcp_pkg::SLEEP_CONTROL_ADDR:
          prdata <= {24'h00_0000, sleep_control_r};
        srcp_pkg::RESET_CAUSE_FLAGS_ADDR:
          prdata <= {26'h000_0000, flags_r};
        srcp_pkg::SOFT_RESET_REGISTER_ADDR:
          prdata <= 32'h0000_0000;
        srcp_pkg::SLEEP_STATUS_ADDR:
          prdata <= {29'h0000_0000, slp_st_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // checks
  a_soft_reset_hold: assert property (@(posedge pclk) disable iff (!presetn)
    soft_req |=> !sys_reset_n) else $error("soft reset not applied");
  a_soft_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(pready) && !pwrite &&
    $past(paddr) == srcp_pkg::SOFT_RESET_REGISTER_ADDR |-> prdata == 0)
    else $error("soft reset trigger read nonzero");
  a_supply_drop_reset: assert property (@(posedge pclk) disable iff (!presetn)
    supply_low_s |=> !sys_reset_n && flags_r == 6'h01)
    else $error("supply drop missed");
  a_pin_holds_reset: assert property (@(posedge pclk) disable iff (!presetn)
    reset_pin_config && !pin_n_s |=> !sys_reset_n)
    else $error("pin reset not held");
  a_pin_fuse_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !reset_pin_config |-> !src_vec[srcp_pkg::FLAG_PIN])
    else $error("pin reset while disabled");
  a_cause_recorded: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_timeout && !supply_low_s |=> flags_r[srcp_pkg::FLAG_WATCHDOG])
    else $error("watchdog cause lost");
  a_debug_break_wake: assert property (@(posedge pclk) disable iff (!presetn)
    slp_st_r == srcp_pkg::SLP_ASLEEP && debug_break && !in_reset
    |=> slp_st_r == srcp_pkg::SLP_WAKING) else $error("break no wake");
  a_idle_wake_six: assert property (@(posedge pclk) disable iff (!presetn)
    slp_st_r == srcp_pkg::SLP_WAKING && wake_len_r == 16'(WAKE_CNT) &&
    !bod_wait && $past(slp_st_r) == srcp_pkg::SLP_ASLEEP && !in_reset
    |-> ##6 slp_st_r == srcp_pkg::SLP_ACTIVE || in_reset)
    else $error("idle wake not six cycles");
  a_bod_wait_hold: assert property (@(posedge pclk) disable iff (!presetn)
    slp_st_r == srcp_pkg::SLP_WAKING && bod_wait && !bod_ready_s &&
    !in_reset |=> slp_st_r != srcp_pkg::SLP_ACTIVE || in_reset)
    else $error("woke before detector ready");
  a_bod_forced_min: assert property (@(posedge pclk) disable iff (!presetn)
    !bod_used_fuse && in_reset |=> bod_level_out == 3'h0)
    else $error("unused detector level not forced");
endmodule

// ===== srcp_far_model.sv
/*
  far-side model: cpu sleep and wake requests, watchdog lapse, debugger
  requests and brown-out detector ready after a wake.
  assumes bench commands are levels set just after a rising pclk edge.
*/
module srcp_far_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench commands
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire logic brk_req,
  input wire logic wdt_req,
  input wire logic dbg_req,
  input wire logic [7:0] rdy_lag,
  // block status
  input wire logic asleep,
  // requests into the block
  output logic sleep_instr,
  output logic wake_irq,
  output logic debug_break,
  output logic watchdog_timeout,
  output logic debug_port_reset,
  output logic brownout_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lag_r;
  // cpu and debugger requests follow the bench commands one clock later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_instr <= 1'b0;
      wake_irq <= 1'b0;
      watchdog_timeout <= 1'b0;
      debug_port_reset <= 1'b0;
      debug_break <= 1'b0;
    end else begin
      sleep_instr <= sleep_req;
      wake_irq <= wake_req;
      watchdog_timeout <= wdt_req;
      debug_port_reset <= dbg_req;
      debug_break <= brk_req;
    end
  end
  // detector restarts on a wake and is ready rdy_lag cycles later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lag_r <= 8'h00;
      brownout_ready <= 1'b1;
    end else begin
      if (asleep && (wake_req || brk_req) && !wake_irq &&
          !debug_break) begin
        lag_r <= rdy_lag;
      end else if (lag_r != 8'h00) begin
        lag_r <= lag_r - 8'h01;
      end
      brownout_ready <= (lag_r == 8'h00);
    end
  end
endmodule

// ===== tb_top.sv
/*
  testbench for srcp_top: apb master, one task per scenario.
  assumes the far-side model drives the same-clock request inputs.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int INIT_N = 4;
  localparam int OSC_N = 8;
  localparam int SUT_N = 2;
  localparam int PWR_N = INIT_N + 3 * SUT_N;
  localparam logic [7:0] A_SC = srcp_pkg::SLEEP_CONTROL_ADDR;
  localparam logic [7:0] A_FL = srcp_pkg::RESET_CAUSE_FLAGS_ADDR;
  localparam logic [7:0] A_SR = srcp_pkg::SOFT_RESET_REGISTER_ADDR;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd_v;
  logic pready, pslverr, err_v;
  logic [1:0] bod_active_fuse = 2'h0;
  logic [2:0] bod_level_fuse = 3'h5;
  logic [2:0] startup_delay_setting = 3'h3;
  logic bod_used_fuse = 1'b0, reset_pin_config = 1'b1;
  logic supply_low = 1'b0, brownout_trip = 1'b0, reset_pin_n = 1'b1;
  logic sleep_req = 1'b0, wake_req = 1'b0, brk_req = 1'b0;
  logic wdt_req = 1'b0, dbg_req = 1'b0;
  logic [7:0] rdy_lag = 8'h00;
  logic watchdog_timeout, debug_port_reset, debug_break, sleep_instr;
  logic wake_irq, brownout_ready, reload_seen;
  logic sys_reset_n, fuse_reload, cpu_run, asleep;
  logic [1:0] sleep_mode_out;
  logic [2:0] bod_level_out;
  int n_fail = 0;
  int comparisons = 0;

  always #5 pclk = ~pclk;
  always @(posedge pclk) if (fuse_reload === 1'b1) reload_seen <= 1'b1;

  srcp_top #(.OSC_CNT(OSC_N), .INIT_CNT(INIT_N), .SUT_STEP(SUT_N)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bod_active_fuse, .bod_level_fuse, .bod_used_fuse,
    .reset_pin_config, .startup_delay_setting, .supply_low, .brownout_trip,
    .brownout_ready, .reset_pin_n, .watchdog_timeout, .debug_port_reset,
    .debug_break, .sleep_instr, .wake_irq, .sys_reset_n, .fuse_reload,
    .cpu_run, .sleep_mode_out, .asleep, .bod_level_out
  );
  srcp_far_model far_u (
    .pclk, .presetn, .sleep_req, .wake_req, .brk_req, .wdt_req, .dbg_req,
    .rdy_lag, .asleep, .sleep_instr, .wake_irq, .debug_break,
    .watchdog_timeout, .debug_port_reset, .brownout_ready
  );

  task close_out;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_rng(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("ERROR t=%0t got=%h lo=%h hi=%h", $time, got, lo, hi);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk_rng(n, 0, 49);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_val(rd_v, exp);
  endtask

  // which: 0 sys_reset_n, 1 cpu_run, 2 asleep
  task wait_for(input int which, input logic lvl, input int mx,
                output int n);
    n = 0;
    while (n < mx) begin
      @(posedge pclk);
      n++;
      if ((which == 0 ? sys_reset_n : which == 1 ? cpu_run : asleep)
          === lvl) break;
    end
  endtask

  task t_power_on;
    int n;
    @(posedge pclk);
    chk_val(bod_level_out, 32'h0);
    wait_for(0, 1'b1, 200, n);
    chk_rng(n, PWR_N, PWR_N + 12);
    rd_chk(A_FL, 32'h0000_0001);
    rd_chk(A_SC, 32'h0000_0000);
    rd_chk(A_SR, 32'h0000_0000);
    apb(1'b1, A_SC, 32'hFFFF_FFFF);
    rd_chk(A_SC, 32'h0000_0007);
    chk_val(sleep_mode_out, 32'h3);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk_val(err_v, 32'h1);
    chk_val(rd_v, 32'h0);
    bod_used_fuse <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_val(bod_level_out, 32'h5);
  endtask

  task t_sleep(input logic [1:0] d, input logic en, input logic [1:0] fz,
               input int lag, input logic brk);
    int n, lo;
    lo = srcp_pkg::WAKE_CYCLES + (d == srcp_pkg::DEPTH_IDLE ? 0 : OSC_N);
    if (lag > lo) lo = lag;
    bod_active_fuse <= fz;
    rdy_lag <= lag[7:0];
    apb(1'b1, A_SC, {29'h0, d, en});
    @(posedge pclk);
    chk_val(sleep_mode_out, d);
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    wait_for(2, 1'b1, 8, n);
    if (!en || d == 2'h3) begin
      chk_val(asleep, 32'h0);
      return;
    end
    chk_rng(n, 1, 6);
    chk_val(cpu_run, 32'h0);
    rd_chk(srcp_pkg::SLEEP_STATUS_ADDR, 32'h0000_0002);
    if (brk) brk_req <= 1'b1;
    else wake_req <= 1'b1;
    wait_for(1, 1'b1, 200, n);
    chk_rng(n, lo, lo + 10);
    chk_val(asleep, 32'h0);
    wake_req <= 1'b0;
    brk_req <= 1'b0;
  endtask

  // k: 0 watchdog, 1 debug port, 2 pin, 3 software, 4 brown-out
  task t_src(input int k);
    int n;
    logic [31:0] fl;
    case (k)
      0: fl = 32'h1 << srcp_pkg::FLAG_WATCHDOG;
      1: fl = 32'h1 << srcp_pkg::FLAG_DEBUG;
      2: fl = 32'h1 << srcp_pkg::FLAG_PIN;
      3: fl = 32'h1 << srcp_pkg::FLAG_SOFTWARE;
      default: fl = 32'h1 << srcp_pkg::FLAG_BROWNOUT;
    endcase
    apb(1'b1, A_FL, 32'h0000_003F);
    rd_chk(A_FL, 32'h0000_0000);
    reload_seen = 1'b0;
    case (k)
      0: wdt_req <= 1'b1;
      1: dbg_req <= 1'b1;
      2: reset_pin_n <= 1'b0;
      3: apb(1'b1, A_SR, 32'h0000_0001);
      default: brownout_trip <= 1'b1;
    endcase
    wait_for(0, 1'b0, 10, n);
    chk_rng(n, 1, 8);
    if (k != 3) begin
      repeat (20) @(posedge pclk);
      chk_val(sys_reset_n, 32'h0);
    end
    wdt_req <= 1'b0;
    dbg_req <= 1'b0;
    reset_pin_n <= 1'b1;
    brownout_trip <= 1'b0;
    wait_for(0, 1'b1, 100, n);
    chk_rng(n, INIT_N, PWR_N + 12);
    chk_val(reload_seen, 32'h1);
    rd_chk(A_FL, fl);
  endtask

  task t_pin_off;
    reset_pin_config <= 1'b0;
    reset_pin_n <= 1'b0;
    repeat (20) @(posedge pclk);
    chk_val(sys_reset_n, 32'h1);
    reset_pin_n <= 1'b1;
    repeat (6) @(posedge pclk);
    reset_pin_config <= 1'b1;
    rd_chk(A_FL, 32'h0000_0002);
  endtask

  task t_supply;
    int n;
    bod_used_fuse <= 1'b0;
    supply_low <= 1'b1;
    wait_for(0, 1'b0, 8, n);
    chk_rng(n, 1, 6);
    repeat (4) @(posedge pclk);
    chk_val(bod_level_out, 32'h0);
    supply_low <= 1'b0;
    wait_for(0, 1'b1, 100, n);
    chk_rng(n, PWR_N, PWR_N + 12);
    rd_chk(A_FL, 32'h0000_0001);
  endtask

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_power_on;
    t_sleep(srcp_pkg::DEPTH_IDLE, 1'b1, 2'h0, 0, 1'b0);
    t_sleep(srcp_pkg::DEPTH_STANDBY, 1'b1, 2'h0, 0, 1'b0);
    t_sleep(srcp_pkg::POWER_DOWN_CODE, 1'b1, 2'h0, 0, 1'b0);
    t_sleep(2'h3, 1'b1, 2'h0, 0, 1'b0);
    t_sleep(srcp_pkg::DEPTH_IDLE, 1'b0, 2'h0, 0, 1'b0);
    t_sleep(2'h0, 1'b1, srcp_pkg::BOD_WAIT_MODE, 40, 1'b0);
    t_sleep(2'h2, 1'b1, srcp_pkg::BOD_WAIT_MODE, 0, 1'b0);
    t_sleep(2'h1, 1'b1, 2'h0, 0, 1'b1);
    for (int k = 0; k < 5; k++) t_src(k);
    t_pin_off;
    t_supply;
    close_out;
  end

  initial begin
    #100_000;
    n_fail++;
    close_out;
  end
endmodule
